// >>> hw/port_d_alt_override.sv
// Alternate function override for the eight pins of port D
// Notes on behaviour
// - Sync clock pin direction follows direction bit
// - Sync clock drives out only in synchronous mode
// - Transmitter enabled forces output, data, no pull-up
// - Receiver enabled forces input, feeds receiver
// - Forced receive pull-up: latch one, pull-ups allowed
// - Two-wire enable makes bit 1 data line
// - Two-wire enable makes bit 0 clock line
// - Two-wire lines open-drain, only pulled low
// - Two-wire inputs drop pulses under 50 ns
// - Enabled external interrupt forces input buffer on
// - Bits 7,6 feed timer counts, no override
// - Bit 4 feeds capture trigger, no override
`timescale 1ns/1ns
`default_nettype none
`include "port_d_regs.svh"

module port_d_alt_override #(
	parameter int SPIKE_CYC = `PD_SPIKE_CYC
) (
	// Clock and reset
	input  wire logic                     CLK_I,
	input  wire logic                     RST_N_I,
	// Port registers
	input  wire logic [7:0]               PORT_OUT_I,
	input  wire logic [7:0]               PORT_DIR_I,
	input  wire logic                     GLOBAL_PULLUP_DISABLE_I,
	input  wire logic                     SLEEP_INPUT_DISABLE_I,
	// Peripheral controls
	input  wire port_d_pkg::serial1_ctl_t SERIAL1_CTL_I,
	input  wire port_d_pkg::two_wire_ctl_t TWO_WIRE_CTL_I,
	input  wire logic [3:0]               EXT_IRQ_ENABLE_I,
	// Peripheral inputs
	output port_d_pkg::periph_in_t        PERIPH_IN_O,
	// Pins
	input  wire logic [7:0]               PIN_IN_I,
	output logic [7:0]                    PIN_OUT_O,
	output logic [7:0]                    PIN_OE_O,
	output logic [7:0]                    PIN_PULLUP_O,
	output logic [7:0]                    PIN_INPUT_EN_O
);

	// ----------------------------------------------------------------
	// Reset release
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_q;
	logic       rst_n;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Pull-up from an output latch bit under the global disable
	function automatic logic pull_from_latch(input logic latch,
		input logic global_pullup_disable);
		return latch & ~global_pullup_disable;
	endfunction

	// ----------------------------------------------------------------
	// Pin input synchroniser
	// ----------------------------------------------------------------
	logic [7:0] pin_meta_q;
	logic [7:0] pin_sync_q;

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			// Matches the filters' idle level, so no false fall after reset
			pin_meta_q <= `PD_PIN_SYNC_RESET;
			pin_sync_q <= `PD_PIN_SYNC_RESET;
		end else begin
			pin_meta_q <= PIN_IN_I;
			pin_sync_q <= pin_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Two-wire spike filters
	// ----------------------------------------------------------------
	logic [1:0] tw_filt;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_tw_filt
			spike_filter #(
				.STABLE_CYC (SPIKE_CYC)
			) u_filt (
				.clk_i   (CLK_I),
				.rst_n_i (rst_n),
				.raw_i   (pin_sync_q[g]),
				.filt_o  (tw_filt[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Pin controls
	// ----------------------------------------------------------------
	logic [7:0]             out_d;
	logic [7:0]             out_q;
	logic [7:0]             oe_d;
	logic [7:0]             oe_q;
	logic [7:0]             pu_d;
	logic [7:0]             pu_q;
	logic [7:0]             ie_d;
	logic [7:0]             ie_q;
	port_d_pkg::periph_in_t per_d;
	port_d_pkg::periph_in_t per_q;
	logic                   global_pullup_disable;
	logic                   tw_en;
	logic                   sync_drv;

	assign global_pullup_disable      = GLOBAL_PULLUP_DISABLE_I;
	assign tw_en    = TWO_WIRE_CTL_I.two_wire_enable;
	assign sync_drv = SERIAL1_CTL_I.sync_mode & PORT_DIR_I[`PD_BIT_SYNC_CLOCK];

	always_comb begin
		// Ordinary port behaviour first, overrides below
		oe_d  = PORT_DIR_I;
		out_d = PORT_OUT_I;
		for (int i = 0; i < 8; i++) begin
			pu_d[i] = pull_from_latch(PORT_OUT_I[i], global_pullup_disable) & ~PORT_DIR_I[i];
		end
		ie_d = {8{~SLEEP_INPUT_DISABLE_I}};

		// Sync clock: direction bit always picks the way
		oe_d[`PD_BIT_SYNC_CLOCK] = PORT_DIR_I[`PD_BIT_SYNC_CLOCK];
		if (sync_drv) begin
			out_d[`PD_BIT_SYNC_CLOCK] = SERIAL1_CTL_I.sync_clock_out;
		end

		if (SERIAL1_CTL_I.transmitter_enable) begin
			oe_d[`PD_BIT_TRANSMIT]  = 1'b1;
			out_d[`PD_BIT_TRANSMIT] = SERIAL1_CTL_I.transmit_data;
			pu_d[`PD_BIT_TRANSMIT]  = 1'b0;
		end

		if (SERIAL1_CTL_I.receiver_enable) begin
			oe_d[`PD_BIT_RECEIVE] = 1'b0;
			pu_d[`PD_BIT_RECEIVE] =
				pull_from_latch(PORT_OUT_I[`PD_BIT_RECEIVE], global_pullup_disable);
		end

		// Open drain: value held low, enable carries the line state
		if (tw_en) begin
			oe_d[`PD_BIT_SDA]  = TWO_WIRE_CTL_I.sda_drive_low;
			out_d[`PD_BIT_SDA] = 1'b0;
			pu_d[`PD_BIT_SDA]  =
				pull_from_latch(PORT_OUT_I[`PD_BIT_SDA], global_pullup_disable);
			oe_d[`PD_BIT_SCL]  = TWO_WIRE_CTL_I.scl_drive_low;
			out_d[`PD_BIT_SCL] = 1'b0;
			pu_d[`PD_BIT_SCL]  =
				pull_from_latch(PORT_OUT_I[`PD_BIT_SCL], global_pullup_disable);
		end

		// Interrupts must see the pin even in sleep
		for (int i = 0; i < `PD_IRQ_LINES; i++) begin
			if (EXT_IRQ_ENABLE_I[i]) begin
				ie_d[i] = 1'b1;
			end
		end

		per_d.timer_zero_count_input    = pin_sync_q[`PD_BIT_TIMER_ZERO];
		per_d.timer_one_count_input     = pin_sync_q[`PD_BIT_TIMER_ONE];
		per_d.timer_one_capture_trigger = pin_sync_q[`PD_BIT_CAPTURE];
		per_d.serial1_receive_data      = pin_sync_q[`PD_BIT_RECEIVE];
		per_d.serial1_sync_clock        = pin_sync_q[`PD_BIT_SYNC_CLOCK];
		// Unfiltered path would let ringing through as false edges
		per_d.sda_in                    = tw_filt[`PD_BIT_SDA];
		per_d.scl_in                    = tw_filt[`PD_BIT_SCL];
		per_d.ext_irq_line              = pin_sync_q[3:0] & ie_d[3:0];
	end

	always_ff @(posedge CLK_I or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= 8'h00;
			oe_q  <= 8'h00;
			pu_q  <= 8'h00;
			ie_q  <= 8'h00;
			per_q <= '0;
		end else begin
			out_q <= out_d;
			oe_q  <= oe_d;
			pu_q  <= pu_d;
			ie_q  <= ie_d;
			per_q <= per_d;
		end
	end

	assign PIN_OUT_O      = out_q;
	assign PIN_OE_O       = oe_q;
	assign PIN_PULLUP_O   = pu_q;
	assign PIN_INPUT_EN_O = ie_q;
	assign PERIPH_IN_O    = per_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_sync_clk_dir: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		$past(rst_n) |-> PIN_OE_O[5] == $past(PORT_DIR_I[5]))
		else $error("sync clock pin direction not from direction bit");

	a_sync_clk_drive: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		SERIAL1_CTL_I.sync_mode && PORT_DIR_I[5]
		|=> PIN_OUT_O[5] == $past(SERIAL1_CTL_I.sync_clock_out))
		else $error("sync clock not driven in synchronous mode");

	a_sync_clk_idle: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		!SERIAL1_CTL_I.sync_mode |=> PIN_OUT_O[5] == $past(PORT_OUT_I[5]))
		else $error("sync clock pin overridden outside synchronous mode");

	a_tx_pin_force: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		SERIAL1_CTL_I.transmitter_enable |=> PIN_OE_O[3] && !PIN_PULLUP_O[3]
		&& PIN_OUT_O[3] == $past(SERIAL1_CTL_I.transmit_data))
		else $error("transmit pin not forced to output");

	a_rx_pin_input: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		SERIAL1_CTL_I.receiver_enable |=> !PIN_OE_O[2])
		else $error("receive pin not forced to input");

	a_rx_data_route: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		$past(rst_n, 3) |->
		PERIPH_IN_O.serial1_receive_data == $past(PIN_IN_I[2], 3))
		else $error("receive data not taken from the pin");

	a_rx_pullup: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		SERIAL1_CTL_I.receiver_enable |=>
		PIN_PULLUP_O[2] == ($past(PORT_OUT_I[2]) && !$past(global_pullup_disable)))
		else $error("receive pin pull-up wrong");

	a_sda_line: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		tw_en |=> PIN_OE_O[1] == $past(TWO_WIRE_CTL_I.sda_drive_low))
		else $error("data line not steered by the interface");

	a_scl_line: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		tw_en |=> PIN_OE_O[0] == $past(TWO_WIRE_CTL_I.scl_drive_low))
		else $error("clock line not steered by the interface");

	a_tw_open_drain: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		tw_en |=> PIN_OUT_O[1:0] == 2'h0)
		else $error("two-wire line driven high");

	a_irq_buffer_on: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		EXT_IRQ_ENABLE_I[0] && SLEEP_INPUT_DISABLE_I |=> PIN_INPUT_EN_O[0])
		else $error("input buffer off under enabled interrupt");

	a_timer_pins_plain: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		$past(rst_n) |-> PIN_OE_O[7:6] == $past(PORT_DIR_I[7:6])
		&& PIN_OUT_O[7:6] == $past(PORT_OUT_I[7:6]))
		else $error("timer count pins overridden");

	a_capture_plain: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		$past(rst_n) |-> PIN_OE_O[4] == $past(PORT_DIR_I[4])
		&& PIN_OUT_O[4] == $past(PORT_OUT_I[4]))
		else $error("capture pin overridden");

	a_no_override: assert property (
		@(posedge CLK_I) disable iff (!rst_n)
		!SERIAL1_CTL_I.transmitter_enable |=> PIN_OE_O[3] == $past(PORT_DIR_I[3])
		&& PIN_PULLUP_O[3] == ($past(PORT_OUT_I[3]) && !$past(global_pullup_disable)
		&& !$past(PORT_DIR_I[3])))
		else $error("idle transmit pin does not follow port");

endmodule // port_d_alt_override

`default_nettype wire

// >>> hw/port_d_pkg.sv
// Types shared by the port D override block
package port_d_pkg;

	typedef struct packed {
		logic sync_mode;
		logic sync_clock_out;
		logic transmitter_enable;
		logic transmit_data;
		logic receiver_enable;
	} serial1_ctl_t;

	typedef struct packed {
		logic two_wire_enable;
		logic sda_drive_low;
		logic scl_drive_low;
	} two_wire_ctl_t;

	typedef struct packed {
		logic       timer_zero_count_input;
		logic       timer_one_count_input;
		logic       timer_one_capture_trigger;
		logic       serial1_receive_data;
		logic       serial1_sync_clock;
		logic       sda_in;
		logic       scl_in;
		logic [3:0] ext_irq_line;
	} periph_in_t;

endpackage

// >>> hw/port_d_regs.svh
// Bit positions and timing constants for the port D override block
`ifndef PORT_D_REGS_SVH
`define PORT_D_REGS_SVH

// ----------------------------------------------------------------
// Pin positions
// ----------------------------------------------------------------
`define PD_BIT_TIMER_ZERO   7
`define PD_BIT_TIMER_ONE    6
`define PD_BIT_SYNC_CLOCK   5
`define PD_BIT_CAPTURE      4
`define PD_BIT_TRANSMIT     3
`define PD_BIT_RECEIVE      2
`define PD_BIT_SDA          1
`define PD_BIT_SCL          0
`define PD_IRQ_LINES        4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
// Both two-wire lines start high, as the idle bus does
`define PD_PIN_SYNC_RESET   8'h03

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PD_CLK_PERIOD_NS    50
`define PD_SPIKE_NS         50
// Least time rounds up, never below one cycle
`define PD_SPIKE_CYC \
	(((`PD_SPIKE_NS + `PD_CLK_PERIOD_NS - 1) / `PD_CLK_PERIOD_NS) < 1 ? 1 : \
	((`PD_SPIKE_NS + `PD_CLK_PERIOD_NS - 1) / `PD_CLK_PERIOD_NS))

`endif

// >>> hw/spike_filter.sv
// Spike filter for one two-wire line
`timescale 1ns/1ns
`default_nettype none

module spike_filter #(
	parameter int STABLE_CYC = 1
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Line
	input  wire logic raw_i,
	output logic      filt_o
);

	logic       filt_q;
	logic       filt_d;
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// A change passes only after STABLE_CYC + 1 equal samples, so a
	// pulse seen in a single sample never reaches the interface
	always_comb begin
		filt_d = filt_q;
		cnt_d  = 4'h0;
		if (raw_i != filt_q) begin
			if (cnt_q == 4'(STABLE_CYC)) begin
				filt_d = raw_i;
			end else begin
				cnt_d = cnt_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			filt_q <= 1'b1;
			cnt_q  <= 4'h0;
		end else begin
			filt_q <= filt_d;
			cnt_q  <= cnt_d;
		end
	end

	assign filt_o = filt_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_filter_change_late: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(filt_q != $past(filt_q)) |-> ($past(cnt_q) == 4'(STABLE_CYC)))
		else $error("filter output changed before the line settled");

	a_filter_spike_drop: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(raw_i != filt_q) && (cnt_q == 4'h0) ##1 (raw_i == filt_q)
		|=> $stable(filt_q))
		else $error("single sample spike reached the output");

endmodule // spike_filter

`default_nettype wire

// >>> tb/pin_world.sv
// Package pin model: resolves each pin from chip drive, board drive, pull-up
`timescale 1ns/1ns
`default_nettype none

module pin_world (
	// Clock
	input  wire logic       clk_i,
	// Chip side
	input  wire logic [7:0] out_i,
	input  wire logic [7:0] oe_i,
	input  wire logic [7:0] pullup_i,
	// Board side
	input  wire logic [7:0] ext_en_i,
	input  wire logic [7:0] ext_val_i,
	// Resolved pins
	output logic [7:0]      level_o,
	output logic [7:0]      float_o
);
	// ----------------------------------------------------------------
	// Floating pins show a changing pattern, never a held value
	// ----------------------------------------------------------------
	logic [7:0] flip_q = 8'h5A;

	always @(posedge clk_i) begin
		flip_q <= ~flip_q;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			float_o[i] = 1'b0;
			if (oe_i[i])
				level_o[i] = out_i[i] & (~ext_en_i[i] | ext_val_i[i]);
			else if (ext_en_i[i])
				level_o[i] = ext_val_i[i];
			else if (pullup_i[i])
				level_o[i] = 1'b1;
			else begin
				level_o[i] = flip_q[i];
				float_o[i] = 1'b1;
			end
		end
	end
endmodule // pin_world

`default_nettype wire

// >>> tb/tb_port_d_alt_function_override.sv
// Self-checking bench for the port D override block
`timescale 1ns/1ns
`default_nettype none

module tb_port_d_alt_function_override;
	typedef struct packed {
		logic [7:0]                lat;
		logic [7:0]                dir;
		logic                      global_pullup_disable;
		logic                      slp;
		port_d_pkg::serial1_ctl_t  ser;
		port_d_pkg::two_wire_ctl_t tw;
		logic [3:0]                irq;
		logic [7:0]                xen;
		logic [7:0]                xval;
	} stim_t;

	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	stim_t                  st = '0;
	logic [7:0]             lvl, flt, p_out, p_oe, p_pu, p_ie;
	port_d_pkg::periph_in_t per, ep, m;
	logic [63:0]            r;
	integer                 seed = 27452;
	int                     num_errors = 0;
	int                     cmp_count = 0;
	int                     cyc = 0;

	always #25 clk = ~clk;

	port_d_alt_override port_d_alt_override_inst (
		.CLK_I(clk), .RST_N_I(rst_n), .PORT_OUT_I(st.lat),
		.PORT_DIR_I(st.dir), .GLOBAL_PULLUP_DISABLE_I(st.global_pullup_disable),
		.SLEEP_INPUT_DISABLE_I(st.slp), .SERIAL1_CTL_I(st.ser),
		.TWO_WIRE_CTL_I(st.tw), .EXT_IRQ_ENABLE_I(st.irq),
		.PERIPH_IN_O(per), .PIN_IN_I(lvl), .PIN_OUT_O(p_out),
		.PIN_OE_O(p_oe), .PIN_PULLUP_O(p_pu), .PIN_INPUT_EN_O(p_ie)
	);

	pin_world pin_world_inst (
		.clk_i(clk), .out_i(p_out), .oe_i(p_oe), .pullup_i(p_pu),
		.ext_en_i(st.xen), .ext_val_i(st.xval), .level_o(lvl),
		.float_o(flt)
	);

	// ----------------------------------------------------------------
	// Expected values
	// ----------------------------------------------------------------
	function automatic logic [31:0] exp_pins(stim_t s);
		logic [7:0] o, e, p, n;
		o = s.lat;
		e = s.dir;
		p = s.lat & ~s.dir & {8{~s.global_pullup_disable}};
		n = {8{~s.slp}};
		n[3:0] = n[3:0] | s.irq;
		if (s.ser.sync_mode && s.dir[5]) o[5] = s.ser.sync_clock_out;
		if (s.ser.transmitter_enable) begin
			o[3] = s.ser.transmit_data;
			e[3] = 1'b1;
			p[3] = 1'b0;
		end
		if (s.ser.receiver_enable) begin
			e[2] = 1'b0;
			p[2] = s.lat[2] & ~s.global_pullup_disable;
		end
		if (s.tw.two_wire_enable) begin
			o[1:0] = 2'h0;
			e[1:0] = {s.tw.sda_drive_low, s.tw.scl_drive_low};
			p[1:0] = s.lat[1:0] & {2{~s.global_pullup_disable}};
		end
		return {o, e, p, n};
	endfunction

	function automatic port_d_pkg::periph_in_t exp_per(logic [7:0] l,
			logic [3:0] ie);
		return '{l[7], l[6], l[4], l[2], l[5], l[1], l[0], l[3:0] & ie};
	endfunction

	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
			num_errors++;
		end
	endtask

	// Holds a vector long enough for sync and filter paths to settle
	task automatic apply(stim_t v);
		logic [31:0] e;
		st = v;
		repeat (8) @(negedge clk);
		e = exp_pins(v);
		chk("pins", e, {p_out, p_oe, p_pu, p_ie});
		ep = exp_per(lvl, e[3:0]);
		m = exp_per(~flt, 4'hF);
		if (!v.tw.two_wire_enable) begin
			m.sda_in = 1'b0;
			m.scl_in = 1'b0;
		end
		chk("periph", 32'(ep & m), 32'(per & m));
	endtask

	task automatic stop_test();
		if (num_errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			stop_test();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		stim_t v;
		r = {$random(seed), $random(seed)};
		@(negedge clk);
		st = r[45:0];
		repeat (2) @(negedge clk);
		chk("reset", 32'h0, {p_out, p_oe, p_pu, p_ie});
		chk("reset_per", 32'h0, 32'(per));
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		// Every serial and two-wire override combination, interrupt enables and rest random
		for (int k = 0; k < 64; k++) begin
			r = {$random(seed), $random(seed)};
			v = r[45:0];
			v.ser.transmitter_enable = k[0];
			v.ser.receiver_enable = k[1];
			v.tw.two_wire_enable = k[2];
			v.ser.sync_mode = k[3];
			v.global_pullup_disable = k[4];
			v.dir[5] = k[5];
			apply(v);
		end
		for (int k = 0; k < 150; k++) begin
			r = {$random(seed), $random(seed)};
			apply(r[45:0]);
		end
		// One-cycle dips on idle two-wire lines are dropped
		for (int b = 0; b < 2; b++) begin
			v = '0;
			v.tw.two_wire_enable = 1'b1;
			v.xen = 8'h03;
			v.xval = 8'h03;
			apply(v);
			st.xval[b] = 1'b0;
			@(negedge clk);
			st.xval[b] = 1'b1;
			for (int c = 0; c < 8; c++) begin
				@(negedge clk);
				chk("line_spike", 32'h1, 32'(per[4 + b]));
			end
			st.xval[b] = 1'b0;
			repeat (8) @(negedge clk);
			chk("line_low", 32'h0, 32'(per[4 + b]));
		end
		stop_test();
	end
endmodule // tb_port_d_alt_function_override

`default_nettype wire
